// >>> hw/rdc_pkg.sv
// Purpose: shared constants and types for the read dummy and drive configuration block
// Assumes: 8-bit command opcodes and 8-bit register bytes
// Notes:   bit positions, opcodes, reset values and decode results are named here; assertions and bench also use literal values
package rdc_pkg;

  // read commands whose turnaround length this block decides
  localparam logic [7:0] OP_FAST_READ       = 8'h0B;
  localparam logic [7:0] OP_FAST_READ_DTR   = 8'h0D;
  localparam logic [7:0] OP_DUAL_OUT_READ   = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ    = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_DTR     = 8'hBD;
  localparam logic [7:0] OP_QUAD_OUT_READ   = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO_READ    = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_DTR     = 8'hED;
  localparam logic [7:0] OP_UNIQUE_ID_READ  = 8'h4B;
  localparam logic [7:0] OP_DISC_PARAM_READ = 8'h5A;
  localparam logic [7:0] OP_INFO_ROW_READ   = 8'h68;

  // register set commands
  localparam logic [7:0] OP_SET_EXT_PERSIST = 8'h85;
  localparam logic [7:0] OP_SET_EXT_WORK    = 8'h83;
  localparam logic [7:0] OP_SET_PAR_PERSIST = 8'h65;
  localparam logic [7:0] OP_SET_PAR_WORK_A  = 8'hC0;
  localparam logic [7:0] OP_SET_PAR_WORK_B  = 8'h63;

  // register pairs
  localparam int          NUM_PAIRS       = 2;
  localparam int          PAIR_READ       = 0;
  localparam int          PAIR_EXT        = 1;
  localparam logic [7:0]  READ_PAR_RESET  = 8'h00;
  localparam logic [7:0]  EXT_PAR_RESET   = 8'hFF;

  // field positions
  localparam int DUMMY_FIELD_MSB   = 6;
  localparam int DUMMY_FIELD_LSB   = 3;
  localparam int DRIVE_SEL_MSB     = 7;
  localparam int DRIVE_SEL_LSB     = 5;
  localparam int EXT_RESERVED_MSB  = 4;

  // turnaround counts used when the dummy field is zero
  localparam logic [3:0] DUMMY_DEFAULT_SINGLE  = 4'h8;
  localparam logic [3:0] DUMMY_DEFAULT_QUAD    = 4'h6;
  localparam logic [3:0] DUMMY_DEFAULT_DUAL_IO = 4'h4;
  localparam logic [3:0] DUMMY_FIELD_ZERO      = 4'h0;

  // drive strength codes and their weights in eighths of full strength
  localparam logic [2:0] DRIVE_CODE_RSV_A = 3'h0;
  localparam logic [2:0] DRIVE_CODE_12P5  = 3'h1;
  localparam logic [2:0] DRIVE_CODE_25    = 3'h2;
  localparam logic [2:0] DRIVE_CODE_37P5  = 3'h3;
  localparam logic [2:0] DRIVE_CODE_RSV_B = 3'h4;
  localparam logic [2:0] DRIVE_CODE_75    = 3'h5;
  localparam logic [2:0] DRIVE_CODE_100   = 3'h6;
  localparam logic [2:0] DRIVE_CODE_50    = 3'h7;
  localparam logic [3:0] WEIGHT_RESERVED  = 4'h0;
  localparam logic [3:0] WEIGHT_12P5      = 4'h1;
  localparam logic [3:0] WEIGHT_25        = 4'h2;
  localparam logic [3:0] WEIGHT_37P5      = 4'h3;
  localparam logic [3:0] WEIGHT_50        = 4'h4;
  localparam logic [3:0] WEIGHT_75        = 4'h6;
  localparam logic [3:0] WEIGHT_100       = 4'h8;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_LOAD  = 3'b010,
    ST_READY = 3'b100
  } ctl_state_type;

endpackage

// >>> hw/param_pair_if.sv
// Purpose: carrier between the controller and one persistent/working register pair
// Assumes: single clock domain
// Notes:   owner drives writes and load, store returns both copies
interface param_pair_if;
  logic       wr_persistent;
  logic       wr_working;
  logic       load;
  logic [7:0] wr_data;
  logic [7:0] persistent;
  logic [7:0] working;

  modport owner (output wr_persistent, output wr_working, output load, output wr_data,
                 input persistent, input working);
  modport store (input wr_persistent, input wr_working, input load, input wr_data,
                 output persistent, output working);
endinterface

// >>> hw/nv_param_pair.sv
// Purpose: one persistent copy and one working copy of a parameter byte
// Assumes: load and writes never coincide; controller keeps them apart
// Notes:   persistent copy stands in for the non-volatile cell, reset gives its factory value
module nv_param_pair
  import rdc_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic    clk_sys_in,
  input  wire logic    rst_n_in,
  param_pair_if.store  pair
);

  logic [7:0] persistent;
  logic [7:0] working;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      persistent <= RESET_VALUE;
    end else if (pair.wr_persistent) begin
      persistent <= pair.wr_data;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      working <= RESET_VALUE;
    end else if (pair.load) begin
      working <= persistent;
    end else if (pair.wr_working) begin
      working <= pair.wr_data;
    end
  end

  assign pair.persistent = persistent;
  assign pair.working    = working;

endmodule // nv_param_pair

// >>> hw/read_dummy_and_drive_config.sv
// Purpose: turnaround length of fast reads and output drive selection of a serial flash
// Assumes: commands arrive decoded, one strobe per opcode, from logic on clk_sys_in
// Notes:   commands are held off until the working copies are loaded
// Function
// - dummy count comes from four-bit parameter field
// - zero field gives per-command defaults 8/6/4
// - id, parameter, info-row reads follow fast read
// - dual I/O DTR read refused in QPI
// - extended bits 7..5 select drive strength
// - drive code weights; 111 default, 000/100 reserved
// - extended bits 4..0 are plain storage
// - 85h writes persistent, 83h writes working copy
// - persistent write leaves working copy untouched
// - working copies load from persistent after reset
module read_dummy_and_drive_config
  import rdc_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [7:0] cmd_opcode_in,
  input  wire logic [7:0] cmd_data_in,
  input  wire logic       qpi_mode_in,
  output wire logic       cmd_ready_out,
  output logic            read_start_out,
  output logic            read_refused_out,
  output logic      [3:0] dummy_count_out,
  output logic      [7:0] read_params_out,
  output logic      [7:0] ext_params_out,
  output logic      [2:0] drive_sel_out,
  output logic      [3:0] drive_weight_out,
  output logic            drive_code_reserved_out
);

  function automatic logic is_read_cmd(input logic [7:0] op);
    is_read_cmd = (op == OP_FAST_READ)      || (op == OP_FAST_READ_DTR)  ||
                  (op == OP_DUAL_OUT_READ)  || (op == OP_DUAL_IO_READ)   ||
                  (op == OP_DUAL_IO_DTR)    || (op == OP_QUAD_OUT_READ)  ||
                  (op == OP_QUAD_IO_READ)   || (op == OP_QUAD_IO_DTR)    ||
                  (op == OP_UNIQUE_ID_READ) || (op == OP_DISC_PARAM_READ) ||
                  (op == OP_INFO_ROW_READ);
  endfunction

  function automatic logic is_fast_like(input logic [7:0] op);
    is_fast_like = (op == OP_FAST_READ) || (op == OP_FAST_READ_DTR) ||
                   (op == OP_UNIQUE_ID_READ) || (op == OP_DISC_PARAM_READ) ||
                   (op == OP_INFO_ROW_READ);
  endfunction

  function automatic logic [3:0] default_dummy(input logic [7:0] op, input logic qpi);
    if (is_fast_like(op)) begin
      default_dummy = qpi ? DUMMY_DEFAULT_QUAD : DUMMY_DEFAULT_SINGLE;
    end else if ((op == OP_DUAL_IO_READ) || (op == OP_DUAL_IO_DTR)) begin
      default_dummy = DUMMY_DEFAULT_DUAL_IO;
    end else if ((op == OP_QUAD_IO_READ) || (op == OP_QUAD_IO_DTR)) begin
      default_dummy = DUMMY_DEFAULT_QUAD;
    end else begin
      default_dummy = DUMMY_DEFAULT_SINGLE;
    end
  endfunction

  function automatic logic [3:0] drive_weight(input logic [2:0] code);
    case (code)
      DRIVE_CODE_12P5: drive_weight = WEIGHT_12P5;
      DRIVE_CODE_25:   drive_weight = WEIGHT_25;
      DRIVE_CODE_37P5: drive_weight = WEIGHT_37P5;
      DRIVE_CODE_75:   drive_weight = WEIGHT_75;
      DRIVE_CODE_100:  drive_weight = WEIGHT_100;
      DRIVE_CODE_50:   drive_weight = WEIGHT_50;
      default:         drive_weight = WEIGHT_RESERVED;
    endcase
  endfunction

  ctl_state_type state;
  ctl_state_type next_state;

  param_pair_if pairs[NUM_PAIRS] ();

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PAIRS; gi = gi + 1) begin : gen_pair
      nv_param_pair #(
        .RESET_VALUE (gi == PAIR_EXT ? EXT_PAR_RESET : READ_PAR_RESET)
      ) u_pair (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .pair       (pairs[gi])
      );
      assign pairs[gi].load    = (state == ST_LOAD);
      assign pairs[gi].wr_data = cmd_data_in;
    end
  endgenerate

  wire logic       cmd_take;
  wire logic       op_is_read;
  wire logic       op_refused;
  wire logic       take_read;
  wire logic       take_refuse;
  wire logic [7:0] read_work;
  wire logic [7:0] ext_work;
  wire logic [3:0] dummy_count_field;
  wire logic [3:0] next_dummy;
  wire logic [2:0] drive_sel_work;

  assign cmd_ready_out = (state == ST_READY);
  assign cmd_take      = cmd_valid_in & cmd_ready_out;
  assign op_is_read    = is_read_cmd(cmd_opcode_in);
  assign op_refused    = qpi_mode_in & (cmd_opcode_in == OP_DUAL_IO_DTR);
  assign take_read     = cmd_take & op_is_read & ~op_refused;
  assign take_refuse   = cmd_take & op_is_read & op_refused;

  // set commands: persistent and working copies are written separately
  assign pairs[PAIR_EXT].wr_persistent  = cmd_take & (cmd_opcode_in == OP_SET_EXT_PERSIST);
  assign pairs[PAIR_EXT].wr_working     = cmd_take & (cmd_opcode_in == OP_SET_EXT_WORK);
  assign pairs[PAIR_READ].wr_persistent = cmd_take & (cmd_opcode_in == OP_SET_PAR_PERSIST);
  assign pairs[PAIR_READ].wr_working    = cmd_take & ((cmd_opcode_in == OP_SET_PAR_WORK_A) ||
                                                      (cmd_opcode_in == OP_SET_PAR_WORK_B));

  assign read_work         = pairs[PAIR_READ].working;
  assign ext_work          = pairs[PAIR_EXT].working;
  assign dummy_count_field = read_work[DUMMY_FIELD_MSB:DUMMY_FIELD_LSB];
  assign next_dummy        = (dummy_count_field != DUMMY_FIELD_ZERO) ? dummy_count_field
                                                                     : default_dummy(cmd_opcode_in, qpi_mode_in);
  assign drive_sel_work    = ext_work[DRIVE_SEL_MSB:DRIVE_SEL_LSB];

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: next_state = ST_LOAD;
      ST_LOAD:  next_state = ST_READY;
      ST_READY: next_state = ST_READY;
      default:  next_state = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_start_out   <= 1'b0;
      read_refused_out <= 1'b0;
      dummy_count_out  <= DUMMY_DEFAULT_SINGLE;
    end else begin
      read_start_out   <= take_read;
      read_refused_out <= take_refuse;
      if (take_read) begin
        dummy_count_out <= next_dummy;
      end
    end
  end

  // reserved low bits travel through untouched and steer nothing
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_params_out         <= READ_PAR_RESET;
      ext_params_out          <= EXT_PAR_RESET;
      drive_sel_out           <= DRIVE_CODE_50;
      drive_weight_out        <= WEIGHT_50;
      drive_code_reserved_out <= 1'b0;
    end else begin
      read_params_out         <= read_work;
      ext_params_out          <= ext_work;
      drive_sel_out           <= drive_sel_work;
      drive_weight_out        <= drive_weight(drive_sel_work);
      drive_code_reserved_out <= (drive_sel_work == DRIVE_CODE_RSV_A) ||
                                 (drive_sel_work == DRIVE_CODE_RSV_B);
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  AST_FIELD_COUNT: assert property (
    take_read && (dummy_count_field != DUMMY_FIELD_ZERO) |=> dummy_count_out == $past(dummy_count_field))
    else $error("nonzero dummy field not used as count");

  AST_DEFAULT_SPI_FAST: assert property (
    take_read && (dummy_count_field == DUMMY_FIELD_ZERO) && !qpi_mode_in &&
    ((cmd_opcode_in == OP_FAST_READ) || (cmd_opcode_in == OP_DUAL_OUT_READ) ||
     (cmd_opcode_in == OP_QUAD_OUT_READ)) |=> dummy_count_out == 4'h8)
    else $error("single fast read default is not 8");

  AST_DEFAULT_QUAD: assert property (
    take_read && (dummy_count_field == DUMMY_FIELD_ZERO) &&
    ((cmd_opcode_in == OP_QUAD_IO_READ) || (cmd_opcode_in == OP_QUAD_IO_DTR) ||
     (qpi_mode_in && (cmd_opcode_in == OP_FAST_READ_DTR))) |=> dummy_count_out == 4'h6)
    else $error("quad or qpi fast default is not 6");

  AST_DEFAULT_DUAL_IO: assert property (
    take_read && (dummy_count_field == DUMMY_FIELD_ZERO) &&
    ((cmd_opcode_in == OP_DUAL_IO_READ) || (cmd_opcode_in == OP_DUAL_IO_DTR)) |=> dummy_count_out == 4'h4)
    else $error("dual io default is not 4");

  AST_ID_READS_LIKE_FAST: assert property (
    take_read && !qpi_mode_in && (dummy_count_field == DUMMY_FIELD_ZERO) &&
    ((cmd_opcode_in == OP_UNIQUE_ID_READ) || (cmd_opcode_in == OP_INFO_ROW_READ) ||
     (cmd_opcode_in == OP_DISC_PARAM_READ)) |=> dummy_count_out == 4'h8 && read_start_out)
    else $error("id style read differs from fast read");

  AST_DTR_DUAL_QPI_REFUSED: assert property (
    cmd_take && qpi_mode_in && (cmd_opcode_in == OP_DUAL_IO_DTR) |=>
    read_refused_out && !read_start_out && $stable(dummy_count_out))
    else $error("dual io dtr accepted in qpi");

  AST_PERSIST_ONLY: assert property (
    cmd_take && (cmd_opcode_in == OP_SET_EXT_PERSIST) |=>
    pairs[PAIR_EXT].persistent == $past(cmd_data_in) && $stable(ext_work))
    else $error("persistent write disturbed working copy");

  AST_WORKING_WRITE: assert property (
    cmd_take && (cmd_opcode_in == OP_SET_EXT_WORK) |-> ##2
    ext_params_out == $past(cmd_data_in, 2) && drive_sel_out == $past(cmd_data_in[7:5], 2))
    else $error("working write not visible two cycles later");

  AST_RESERVED_KEPT: assert property (
    cmd_take && (cmd_opcode_in == OP_SET_EXT_WORK) |-> ##2
    ext_params_out[EXT_RESERVED_MSB:0] == $past(cmd_data_in[4:0], 2))
    else $error("reserved extended bits not stored");

  AST_DRIVE_FULL: assert property (
    drive_sel_out == DRIVE_CODE_100 |-> drive_weight_out == 4'h8 && !drive_code_reserved_out)
    else $error("code 110 is not full strength");

  AST_DRIVE_RESERVED: assert property (
    drive_code_reserved_out |-> drive_weight_out == 4'h0 && drive_sel_out[1:0] == 2'h0)
    else $error("reserved drive code mis-flagged");

  AST_POWER_UP_LOAD: assert property (
    state == ST_LOAD |=> cmd_ready_out && read_work == $past(pairs[PAIR_READ].persistent) &&
    ext_work == $past(pairs[PAIR_EXT].persistent))
    else $error("working copies not loaded before ready");

  AST_NO_CMD_BEFORE_LOAD: assert property (
    state != ST_READY |=> !read_start_out && !read_refused_out)
    else $error("command taken before load finished");

endmodule // read_dummy_and_drive_config

// >>> dv/flash_host_model.sv
// Purpose: host controller that presents decoded commands to the read configuration block
// Assumes: commands change at the falling edge and stand until the edge that takes them
// Notes:   strict low lets the bench send a dual I/O double-rate read in QPI on purpose
module flash_host_model
  import rdc_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       cmd_ready_in,
  output logic            cmd_valid_out,
  output logic      [7:0] cmd_opcode_out,
  output logic      [7:0] cmd_data_out,
  output logic            qpi_mode_out,
  output logic            mode_nibble_hiz_out,
  output logic            timed_out_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       strict;
  logic [3:0] field_set;
  wire  logic [3:0] mode_cycles;

  // mode byte takes 4 cycles on two lines, 2 on four lines
  assign mode_cycles = (cmd_opcode_out == OP_DUAL_IO_READ || cmd_opcode_out == OP_DUAL_IO_DTR) ? 4'h4 : 4'h2;
  // low mode nibble released when the turnaround equals the mode byte
  assign mode_nibble_hiz_out = cmd_valid_out && (field_set == mode_cycles);

  initial begin
    cmd_valid_out = 1'b0;
    cmd_opcode_out = 8'h00;
    cmd_data_out = 8'h00;
    qpi_mode_out = 1'b0;
    timed_out_out = 1'b0;
    strict = 1'b1;
    field_set = 4'h0;
  end

  task automatic hold(input logic [7:0] op, input logic [7:0] data);
    cmd_valid_out = 1'b1;
    cmd_opcode_out = op;
    cmd_data_out = data;
  endtask

  task automatic issue(input logic [7:0] op, input logic [7:0] data, input logic qpi);
    int n;
    @(negedge clk_sys_in);
    // with strict set, no dual I/O double-rate read while in QPI
    if (strict && qpi && op == OP_DUAL_IO_DTR) begin
      return;
    end
    if (op == OP_SET_PAR_WORK_A || op == OP_SET_PAR_WORK_B) begin
      field_set = data[6:3];
    end
    hold(op, data);
    qpi_mode_out = qpi;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (cmd_ready_in !== 1'b1 && n < 20);
    if (n >= 20) begin
      timed_out_out = 1'b1;
    end
  endtask

  task automatic idle();
    @(negedge clk_sys_in);
    cmd_valid_out = 1'b0;
    cmd_opcode_out = ~cmd_opcode_out;
    cmd_data_out = ~cmd_data_out;
    qpi_mode_out = ~qpi_mode_out;
  endtask
endmodule // flash_host_model

// >>> dv/tb_read_dummy_and_drive_config.sv
// Purpose: self-checking bench for turnaround length and drive selection
// Assumes: one command at a time from the host model, checks at falling edges
// Notes:   persistent copies return to factory values at reset, so reload shows factory values
module tb_read_dummy_and_drive_config
  import rdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic rst_n_in;
  wire logic cmd_valid, cmd_ready, qpi_mode, start, refused, rsv, hiz, timed_out;
  wire logic [7:0] opcode, data, rd_par, ext_par;
  wire logic [3:0] dummy, weight;
  wire logic [2:0] drive_sel;
  int fail_count = 0;
  int checked = 0;
  int seed = 96099;
  logic [7:0] rd_w, rd_p, ext_w, ext_p, op;
  logic [3:0] dum;
  logic [7:0] rd_ops [11] = '{OP_FAST_READ, OP_FAST_READ_DTR, OP_DUAL_OUT_READ, OP_DUAL_IO_READ, OP_DUAL_IO_DTR,
    OP_QUAD_OUT_READ, OP_QUAD_IO_READ, OP_QUAD_IO_DTR, OP_UNIQUE_ID_READ, OP_DISC_PARAM_READ, OP_INFO_ROW_READ};

  read_dummy_and_drive_config DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid),
    .cmd_opcode_in(opcode), .cmd_data_in(data), .qpi_mode_in(qpi_mode), .cmd_ready_out(cmd_ready),
    .read_start_out(start), .read_refused_out(refused), .dummy_count_out(dummy), .read_params_out(rd_par),
    .ext_params_out(ext_par), .drive_sel_out(drive_sel), .drive_weight_out(weight), .drive_code_reserved_out(rsv));
  flash_host_model host (.clk_sys_in(clk_sys_in), .cmd_ready_in(cmd_ready), .cmd_valid_out(cmd_valid),
    .cmd_opcode_out(opcode), .cmd_data_out(data), .qpi_mode_out(qpi_mode), .mode_nibble_hiz_out(hiz),
    .timed_out_out(timed_out));

  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    checked++;
    if (seen !== expected) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && checked > 0 && timed_out !== 1'b1) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [3:0] exp_dummy(input logic [7:0] o, input logic q, input logic [3:0] f);
    if (f != 4'h0) return f;
    case (o)
      OP_DUAL_IO_READ, OP_DUAL_IO_DTR: return 4'h4;
      OP_QUAD_IO_READ, OP_QUAD_IO_DTR: return 4'h6;
      OP_DUAL_OUT_READ, OP_QUAD_OUT_READ: return 4'h8;
      default: return q ? 4'h6 : 4'h8;
    endcase
  endfunction

  function automatic logic [3:0] exp_weight(input logic [2:0] c);
    case (c)
      3'h1: return 4'h1;
      3'h2: return 4'h2;
      3'h3: return 4'h3;
      3'h5: return 4'h6;
      3'h6: return 4'h8;
      3'h7: return 4'h4;
      default: return 4'h0;
    endcase
  endfunction

  task automatic check_regs();
    check(rd_par, rd_w);
    check(ext_par, ext_w);
    check({5'h00, drive_sel}, {5'h00, ext_w[7:5]});
    check({4'h0, weight}, {4'h0, exp_weight(ext_w[7:5])});
    check({7'h00, rsv}, {7'h00, ext_w[7:5] == 3'h0 || ext_w[7:5] == 3'h4});
  endtask

  task automatic do_read(input logic [7:0] o, input logic q);
    logic refuse;
    refuse = q && o == OP_DUAL_IO_DTR;
    host.issue(o, 8'h00, q);
    host.idle();
    if (!refuse) dum = exp_dummy(o, q, rd_w[6:3]);
    check({7'h00, start}, {7'h00, !refuse});
    check({7'h00, refused}, {7'h00, refuse});
    check({4'h0, dummy}, {4'h0, dum});
  endtask

  task automatic do_set(input logic [7:0] o, input logic [7:0] d);
    case (o)
      OP_SET_EXT_PERSIST: ext_p = d;
      OP_SET_EXT_WORK: ext_w = d;
      OP_SET_PAR_PERSIST: rd_p = d;
      OP_SET_PAR_WORK_A, OP_SET_PAR_WORK_B: rd_w = d;
      default: ;
    endcase
    host.issue(o, d, 1'b0);
    host.idle();
    check({6'h00, start, refused}, 8'h00);
    @(negedge clk_sys_in);
    check_regs();
  endtask

  task automatic reset_dut();
    rst_n_in = 1'b0;
    @(negedge clk_sys_in);
    // a command held through reset must leave no trace
    host.hold(OP_SET_PAR_WORK_A, 8'h78);
    repeat (9) @(negedge clk_sys_in);
    rd_w = READ_PAR_RESET;
    ext_w = EXT_PAR_RESET;
    rd_p = rd_w;
    ext_p = ext_w;
    dum = 4'h8;
    check({7'h00, cmd_ready}, 8'h00);
    check_regs();
    rst_n_in = 1'b1;
    @(negedge clk_sys_in);
    check({7'h00, cmd_ready}, 8'h00);
    host.idle();
    check({7'h00, cmd_ready}, 8'h01);
    @(negedge clk_sys_in);
    check_regs();
    check({4'h0, dummy}, {4'h0, dum});
  endtask

  initial begin
    reset_dut();
    host.strict = 1'b0;
    for (int q = 0; q < 2; q++) begin
      for (int i = 0; i < 11; i++) begin
        do_read(rd_ops[i], q[0]);
      end
    end
    host.strict = 1'b1;
    for (int f = 1; f < 16; f++) begin
      do_set(f[0] ? OP_SET_PAR_WORK_A : OP_SET_PAR_WORK_B, 8'({$random(seed)} % 8 + f * 8) | (f > 7 ? 8'h80 : 8'h00));
      op = rd_ops[{$random(seed)} % 11];
      // mode-byte reads only with a turnaround long enough for the mode byte
      if (f < 4 && (op == OP_DUAL_IO_READ || op == OP_DUAL_IO_DTR || op == OP_QUAD_IO_READ ||
                    op == OP_QUAD_IO_DTR)) op = OP_FAST_READ;
      do_read(op, 1'b0);
    end
    // set then read on the very next edge
    rd_w = 8'h28;
    host.issue(OP_SET_PAR_WORK_A, rd_w, 1'b0);
    host.issue(OP_QUAD_IO_DTR, 8'h00, 1'b1);
    host.idle();
    check({3'h0, start, dummy}, 8'h15);
    for (int c = 0; c < 8; c++) begin
      do_set(OP_SET_EXT_WORK, {c[2:0], 5'($random(seed))});
    end
    do_set(OP_SET_EXT_PERSIST, 8'($random(seed)));
    do_set(OP_SET_PAR_PERSIST, 8'($random(seed)));
    do_set(8'h01, 8'($random(seed)));
    reset_dut();
    do_read(OP_FAST_READ, 1'b0);
    give_verdict();
  end

  initial begin
    #200us;
    fail_count++;
    give_verdict();
  end
endmodule // tb_read_dummy_and_drive_config
